// ===== design/bcu_pkg.sv
// Purpose: shared constants and types of the branch control unit
// Assumes: 16-bit word-addressed program counter, 8-bit registers
// Notes:   no registers reachable by software
package bcu_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PC_W    = 16;
  localparam int DATA_W  = 8;
  localparam int FLAG_W  = 4;
  localparam int RSEL_W  = 5;
  localparam int CTX_W   = PC_W + FLAG_W + 3;

  // ---------------------------------------------------------------
  // context word layout
  // ---------------------------------------------------------------
  localparam int CTX_PC_LSB   = 0;
  localparam int CTX_FLG_LSB  = 16;
  localparam int CTX_GIE_BIT  = 20;
  localparam int CTX_BKA_BIT  = 21;
  localparam int CTX_BKB_BIT  = 22;

  // ---------------------------------------------------------------
  // reset value and table lsb clear mask
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [7:0]  LSB_CLR = 8'hFE;

  // ---------------------------------------------------------------
  // branch operations presented by the decoder
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BCU_OP_NONE,
    BCU_OP_REL_IMM,
    BCU_OP_REL_REG,
    BCU_OP_TABLE,
    BCU_OP_CALL_COND,
    BCU_OP_CALL,
    BCU_OP_JUMP_COND
  } bcu_op_t;

endpackage

// ===== design/bcu_table_disp.sv
// Purpose: forms the table jump displacement by rotate and mask
// Assumes: operand values already in range 0..7
// Notes:   pure combinational, one generate loop with a pass per bit
`timescale 1ns/1ps
`default_nettype none
module bcu_table_disp (
  // operands
  input  wire logic [7:0] src_i,
  input  wire logic [2:0] rot_i,
  input  wire logic [2:0] mask_i,
  // result
  output logic      [7:0] disp_o
);

  logic [15:0] dbl;
  logic [7:0]  rot;
  logic [7:0]  keep;

  // doubling the byte turns the rotate into a plain shift
  assign dbl = {src_i, src_i} >> rot_i;
  assign rot = dbl[7:0];

  // bit k survives when it lies below the top m bits
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_keep
      assign keep[k] = (k < (8 - mask_i));
    end
  endgenerate

  // lsb always cleared so table slots are two words wide
  assign disp_o = rot & keep & bcu_pkg::LSB_CLR;

endmodule
`default_nettype wire

// ===== design/bcu_branch_ctrl.sv
// Purpose: program-flow unit: relative, table and long branches
// Assumes: decoder presents one op per cycle with operands; register
//          file delivers the selected register value the same cycle
// Notes:   results appear one cycle after the op is presented
//
// How it works
// - relative jump adds sign-extended displacement to pc
// - displacements are 8-bit two's complement
// - base pc already points past the jump
// - table jump rotates, masks, sign-extends, adds
// - table displacement bit zero always cleared
// - rotate 0..7, zero means no rotation
// - mask m clears top m bits plus lsb
// - table jump reaches +126 to -128 words
// - register operand may name any active register
// - taken conditional call pushes context then jumps
// - bit position 0 is lsb, 7 is msb
// - long targets are 16-bit absolute addresses
// - unconditional call pushes same context, then jumps
// - conditional long jump never pushes the stack
// - saved banks cover bank a and bank b
`timescale 1ns/1ps
`default_nettype none
module bcu_branch_ctrl (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  // decoded branch request
  input  wire bcu_pkg::bcu_op_t    op_i,
  input  wire logic [15:0]         next_pc_i,
  input  wire logic [7:0]          imm_disp_i,
  input  wire logic [15:0]         abs_target_i,
  input  wire logic [2:0]          rot_i,
  input  wire logic [2:0]          mask_i,
  input  wire logic [2:0]          bit_pos_i,
  input  wire logic                bit_state_i,
  // register file
  input  wire logic [4:0]          src_sel_i,
  input  wire logic [7:0]          src_data_i,
  // processor context
  input  wire logic [3:0]          alu_flags_i,
  input  wire logic                global_irq_enable_bit_i,
  input  wire logic                bank_a_alt_i,
  input  wire logic                bank_b_alt_i,
  // program counter
  output logic      [15:0]         pc_o,
  output logic                     pc_load_o,
  // address stack push
  output logic                     push_o,
  output logic      [22:0]         push_ctx_o,
  // register file read select
  output logic      [4:0]          src_sel_o,
  // flags are passed back untouched
  output logic      [3:0]          alu_flags_o
);

  // ---------------------------------------------------------------
  // operand shaping
  // ---------------------------------------------------------------
  logic [7:0]  tbl_disp;
  logic [7:0]  rel_disp;
  logic [15:0] rel_ext;
  logic        cond_hit;

  bcu_table_disp u_tbl (
    .src_i  (src_data_i),
    .rot_i  (rot_i),
    .mask_i (mask_i),
    .disp_o (tbl_disp)
  );

  // immediate or register byte, then table form when asked
  always_comb begin
    case (op_i)
      bcu_pkg::BCU_OP_REL_REG: rel_disp = src_data_i;
      bcu_pkg::BCU_OP_TABLE:   rel_disp = tbl_disp;
      default:                 rel_disp = imm_disp_i;
    endcase
  end

  // eight-bit two's complement widened by copying the sign
  assign rel_ext  = {{8{rel_disp[7]}}, rel_disp};
  // bit index picks lsb at zero, msb at seven
  assign cond_hit = (src_data_i[bit_pos_i] == bit_state_i);

  // ---------------------------------------------------------------
  // next-state computation
  // ---------------------------------------------------------------
  logic [15:0] pc_r,   pc_nxt;
  logic        ld_r,   ld_nxt;
  logic        push_r, push_nxt;
  logic [22:0] ctx_r,  ctx_nxt;
  logic [4:0]  sel_r,  sel_nxt;
  logic [3:0]  flg_r,  flg_nxt;

  always_comb begin
    pc_nxt   = pc_r;
    ld_nxt   = 1'b0;
    push_nxt = 1'b0;
    ctx_nxt  = ctx_r;
    sel_nxt  = src_sel_i;
    flg_nxt  = alu_flags_i;
    case (op_i)
      bcu_pkg::BCU_OP_REL_IMM,
      bcu_pkg::BCU_OP_REL_REG,
      bcu_pkg::BCU_OP_TABLE: begin
        // base is the following instruction, not the jump itself
        pc_nxt = next_pc_i + rel_ext;
        ld_nxt = 1'b1;
      end
      bcu_pkg::BCU_OP_CALL_COND,
      bcu_pkg::BCU_OP_CALL: begin
        if ((op_i == bcu_pkg::BCU_OP_CALL) || cond_hit) begin
          push_nxt = 1'b1;
          ctx_nxt  = {bank_b_alt_i, bank_a_alt_i,
                      global_irq_enable_bit_i, alu_flags_i,
                      next_pc_i};
          pc_nxt   = abs_target_i;
        end else begin
          pc_nxt   = next_pc_i;
        end
        ld_nxt = 1'b1;
      end
      bcu_pkg::BCU_OP_JUMP_COND: begin
        // no stack traffic on this form, taken or not
        pc_nxt = cond_hit ? abs_target_i : next_pc_i;
        ld_nxt = 1'b1;
      end
      default: begin
        pc_nxt = pc_r;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // outputs are registered so pc timing never depends on decode depth
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pc_r   <= bcu_pkg::PC_RST;
      ld_r   <= 1'b0;
      push_r <= 1'b0;
      ctx_r  <= 23'h000000;
      sel_r  <= 5'h00;
      flg_r  <= 4'h0;
    end else begin
      pc_r   <= pc_nxt;
      ld_r   <= ld_nxt;
      push_r <= push_nxt;
      ctx_r  <= ctx_nxt;
      sel_r  <= sel_nxt;
      flg_r  <= flg_nxt;
    end
  end

  assign pc_o        = pc_r;
  assign pc_load_o   = ld_r;
  assign push_o      = push_r;
  assign push_ctx_o  = ctx_r;
  assign src_sel_o   = sel_r;
  assign alu_flags_o = flg_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  rel_target_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_REL_IMM) |=>
      (pc_o == 16'($past(next_pc_i) + {{8{$past(imm_disp_i[7])}}, $past(imm_disp_i)})))
    else $error("relative jump target wrong");

  reg_target_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_REL_REG) |=>
      (pc_o == 16'($past(next_pc_i) + {{8{$past(src_data_i[7])}}, $past(src_data_i)})))
    else $error("register jump target wrong");

  tbl_lsb_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_TABLE) |=> (pc_o[0] == $past(next_pc_i[0])))
    else $error("table displacement lsb not cleared");

  tbl_range_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_TABLE) |=>
      ((16'(pc_o - $past(next_pc_i)) <= 16'h007E) ||
       (16'(pc_o - $past(next_pc_i)) >= 16'hFF80)))
    else $error("table jump out of range");

  tbl_norot_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_TABLE && rot_i == 3'h0 && mask_i == 3'h0) |=>
      (pc_o == 16'($past(next_pc_i) +
        {{8{$past(src_data_i[7])}}, $past(src_data_i) & 8'hFE})))
    else $error("zero rotate changed operand");

  tbl_mask_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_TABLE && mask_i == 3'h1) |=>
      (pc_o >= $past(next_pc_i) || pc_o < 16'h0080))
    else $error("mask one left msb set");

  call_push_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_CALL) |=>
      (push_o && pc_o == $past(abs_target_i) &&
       push_ctx_o[15:0] == $past(next_pc_i)))
    else $error("unconditional call did not push and jump");

  ccall_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_CALL_COND && cond_hit) |=>
      (push_o && push_ctx_o[20] == $past(global_irq_enable_bit_i) &&
       push_ctx_o[19:16] == $past(alu_flags_i)))
    else $error("taken call context wrong");

  ctx_bank_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (push_nxt) |=> (push_ctx_o[22:21] == $past({bank_b_alt_i, bank_a_alt_i})))
    else $error("bank selection not saved");

  untaken_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ((op_i == bcu_pkg::BCU_OP_CALL_COND || op_i == bcu_pkg::BCU_OP_JUMP_COND)
     && !cond_hit) |=> (!push_o && pc_o == $past(next_pc_i)))
    else $error("untaken branch not sequential");

  long_absolute_jump_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (op_i == bcu_pkg::BCU_OP_JUMP_COND && cond_hit) |=>
      (!push_o && pc_o == $past(abs_target_i)))
    else $error("long jump pushed or missed target");

  flags_kept_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    1'b1 |=> (alu_flags_o == $past(alu_flags_i)))
    else $error("branch altered flags");

  cov_table_c: cover property (@(posedge ref_clk_i)
    op_i == bcu_pkg::BCU_OP_TABLE && rot_i == 3'h7 && mask_i == 3'h4);
  cov_call_c: cover property (@(posedge ref_clk_i)
    op_i == bcu_pkg::BCU_OP_CALL_COND && cond_hit);
  cov_skip_c: cover property (@(posedge ref_clk_i)
    op_i == bcu_pkg::BCU_OP_JUMP_COND && !cond_hit);
  cov_back_c: cover property (@(posedge ref_clk_i)
    op_i == bcu_pkg::BCU_OP_REL_IMM && imm_disp_i[7]);

endmodule
`default_nettype wire

// ===== verif/bcu_regfile_model.sv
// Purpose: register file model that answers the branch unit's operand reads
// Assumes: read data is combinational and valid in the same cycle as the select
// Notes:   fixed contents, with both sign extremes placed in r0 and r1
`timescale 1ns/1ps
`default_nettype none
module bcu_regfile_model (
  // read port
  input  wire logic [4:0] sel_i,
  output logic      [7:0] data_o
);
  logic [7:0] regs [32];

  // fixed pattern so the bench can reach +127 and -128 by select alone
  initial begin
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'(i * 73 + 5);
    end
    regs[0] = 8'h7F;
    regs[1] = 8'h80;
  end

  // every one of the 32 selects answers, no hole in the map
  assign data_o = regs[sel_i];
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Purpose: self-checking bench for the branch control unit
// Assumes: outputs answer one cycle after the op, inputs change on falling edges
// Notes:   random ops from a fixed seed, with rotate/mask and bit-test sweeps
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic             clk, rst, bst, global_irq_enable_bit, bka, bkb, pc_load, push;
  bcu_pkg::bcu_op_t op;
  logic [15:0]      npc, tgt, pc;
  logic [7:0]       imm, sdata;
  logic [2:0]       rot, msk, bpos;
  logic [4:0]       ssel, ssel_o;
  logic [3:0]       flg, flg_o;
  logic [22:0]      ctx;
  int               fails, n_tests;
  // displacement corners: largest forward, largest backward, zero, minus one
  logic [7:0]       imm_c [4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};

  bcu_regfile_model rf (.sel_i(ssel), .data_o(sdata));

  bcu_branch_ctrl dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .op_i(op), .next_pc_i(npc),
    .imm_disp_i(imm), .abs_target_i(tgt), .rot_i(rot), .mask_i(msk),
    .bit_pos_i(bpos), .bit_state_i(bst), .src_sel_i(ssel), .src_data_i(sdata),
    .alu_flags_i(flg), .global_irq_enable_bit_i(global_irq_enable_bit), .bank_a_alt_i(bka),
    .bank_b_alt_i(bkb), .pc_o(pc), .pc_load_o(pc_load), .push_o(push),
    .push_ctx_o(ctx), .src_sel_o(ssel_o), .alu_flags_o(flg_o));

  // -------------------------------------------------------------------
  // expectation helpers
  // -------------------------------------------------------------------
  // rotate right by b, then clear the top m bits and the lsb
  function automatic logic [7:0] tdisp(logic [7:0] s, logic [2:0] b, logic [2:0] m);
    logic [15:0] d;
    d = {s, s} >> b;
    return d[7:0] & (8'hFF >> m) & 8'hFE;
  endfunction

  function automatic logic [15:0] rel(logic [15:0] base, logic [7:0] d);
    return base + {{8{d[7]}}, d};
  endfunction

  task automatic chk(string nm, logic [22:0] e, logic [22:0] g);
    n_tests++;
    if (e !== g) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // random operands; the caller picks the op and any corner values
  task automatic rnd();
    {npc, tgt} = 32'($urandom);
    {imm, rot, msk, bpos, bst, ssel, flg, global_irq_enable_bit, bka, bkb} = 30'($urandom);
  endtask

  // one op: taken on the next rising edge, answer checked on the falling edge after
  task automatic step();
    logic [15:0] epc;
    logic        tk, ld, cl;
    logic [22:0] ectx;
    logic [3:0]  ef;
    // let the register model answer the new select before it is read
    #1;
    tk = (sdata[bpos] == bst);
    ld = (op != bcu_pkg::BCU_OP_NONE);
    cl = (op == bcu_pkg::BCU_OP_CALL) || (op == bcu_pkg::BCU_OP_CALL_COND && tk);
    case (op)
      bcu_pkg::BCU_OP_REL_IMM:   epc = rel(npc, imm);
      bcu_pkg::BCU_OP_REL_REG:   epc = rel(npc, sdata);
      bcu_pkg::BCU_OP_TABLE:     epc = rel(npc, tdisp(sdata, rot, msk));
      bcu_pkg::BCU_OP_CALL:      epc = tgt;
      bcu_pkg::BCU_OP_CALL_COND: epc = tk ? tgt : npc;
      bcu_pkg::BCU_OP_JUMP_COND: epc = tk ? tgt : npc;
      default:                   epc = pc;
    endcase
    ectx = {bkb, bka, global_irq_enable_bit, flg, npc};
    ef = flg;
    @(posedge clk);
    @(negedge clk);
    chk("pc_load", 23'(ld), 23'(pc_load));
    chk("pc", 23'(epc), 23'(pc));
    chk("push", 23'(cl), 23'(push));
    if (cl) chk("ctx", ectx, ctx);
    chk("flags", 23'(ef), 23'(flg_o));
    chk("src_sel", 23'(ssel), 23'(ssel_o));
  endtask

  // 10 MHz core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // watchdog: a run that never ends counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    fails = 0;
    n_tests = 0;
    rst = 1'b1;
    op = bcu_pkg::BCU_OP_NONE;
    {npc, tgt, imm, rot, msk, bpos, bst, ssel, flg, global_irq_enable_bit, bka, bkb} = '0;
    void'($urandom(97497));
    repeat (6) @(negedge clk);
    chk("rst_out", 23'h000000, {push, pc_load, 5'h00, pc});
    chk("rst_ctx", 23'h000000, ctx);
    chk("rst_side", 23'h000000, {14'h0000, ssel_o, flg_o});
    rst = 1'b0;
    // displacement extremes of both relative forms, back to back
    foreach (imm_c[i]) begin
      rnd();
      op = bcu_pkg::BCU_OP_REL_IMM;
      imm = imm_c[i];
      step();
      rnd();
      op = bcu_pkg::BCU_OP_REL_REG;
      ssel = 5'(i);
      step();
    end
    $display("test relative done");
    // every rotate and mask pair, on both sign extremes and random registers
    for (int k = 0; k < 192; k++) begin
      rnd();
      op = bcu_pkg::BCU_OP_TABLE;
      {msk, rot} = 6'(k);
      if (k < 128) ssel = 5'(k >> 6);
      step();
    end
    $display("test table done");
    // each bit position and state, for call and long jump
    for (int k = 0; k < 64; k++) begin
      rnd();
      op = k[5] ? bcu_pkg::BCU_OP_JUMP_COND : bcu_pkg::BCU_OP_CALL_COND;
      {bpos, bst} = 4'(k);
      step();
    end
    $display("test bit condition done");
    repeat (400) begin
      rnd();
      op = bcu_pkg::bcu_op_t'($urandom_range(0, 6));
      step();
    end
    $display("test random mix done");
    conclude();
  end
endmodule
`default_nettype wire
